// ---- fcs_pkg.sv ----
// package for the parallel nor flash host sequencer
// assumes a 125 mhz core clock and an asynchronous flash on pins
package fcs_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  // strobe phase lengths in ns, rounded up to cycles
  localparam int SETUP_NS = 40;
  localparam int PULSE_NS = 60;
  localparam int CLK_NS = 8;
  localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] PULSE_CYC = 4'((PULSE_NS + CLK_NS - 1) / CLK_NS);
  // software register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  // ctrl field positions
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_GO = 4;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_ERASE_WIN = 3;
  localparam int ST_RB = 4;
  // data bit positions of status outputs
  localparam int POLL_BIT = 7;
  localparam int TOG1_BIT = 6;
  localparam int FAIL_BIT = 5;
  localparam int EWIN_BIT = 3;
  localparam int TOG2_BIT = 2;
  // command words
  localparam logic [15:0] CMD_RESET = 16'h00F0;
  localparam logic [15:0] CMD_UNLK1 = 16'h00AA;
  localparam logic [15:0] CMD_UNLK2 = 16'h0055;
  localparam logic [15:0] CMD_PROG = 16'h00A0;
  localparam logic [15:0] CMD_ID = 16'h0090;
  localparam logic [15:0] CMD_ERASE = 16'h0080;
  localparam logic [15:0] CMD_CHIP = 16'h0010;
  localparam logic [15:0] CMD_SECT = 16'h0030;
  localparam logic [15:0] CMD_BYP = 16'h0020;
  localparam logic [15:0] CMD_BYP_EXIT = 16'h0000;
  localparam logic [15:0] CMD_SUSP = 16'h00B0;
  localparam logic [15:0] CMD_RESUME = 16'h0030;
  localparam logic [17:0] ADR_U1 = 18'h00555;
  localparam logic [17:0] ADR_U2 = 18'h002AA;
  // operations
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_RESET = 4'h1, OP_PROG = 4'h2, OP_ID = 4'h3,
    OP_CHIP = 4'h4, OP_SECT = 4'h5, OP_BYP_ENTER = 4'h6, OP_BYP_PROG = 4'h7,
    OP_BYP_EXIT = 4'h8, OP_SUSP = 4'h9, OP_RESUME = 4'hA
  } fcs_op_e;
  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fcs_cyc_s;
endpackage

// ---- fcs_host.sv ----
// host sequencer for an asynchronous parallel nor flash
// assumes software on a plain one-cycle register port; flash pins external
// Notes on behaviour
// RL1: device latches address on later falling strobe
// RL2: device latches data on first rising strobe
// RL3: sector picked by address bits 17..12
// RL4: command cycles are writes, except data reads
// RL5: upper data byte ignored in command cycles
// RL6: array reads need no command prefix
// RL7: reset command leaves id mode, failure
// RL8: id sequence fourth cycle is a read
// RL9: protect verify returns 00h or 01h
// RL10: bypass program only after bypass entry
// RL11: resume only valid while erase suspended
// RL12: poll bit inverted until program completes
// RL13: protected program shows busy about 2us
// RL14: erase poll bit zero until done/suspended
// RL15: all protected erase busy about 100us
// RL16: trust other bits after true datum seen
// RL17: ready_busy_n open drain low while busy
// RL18: status valid from final write strobe
// RL19: toggle_bit_one inverts per read while busy
// RL20: toggle_bit_one stops in erase suspend
// RL21: toggle_bit_two toggles in erase sectors
// RL22: read twice, recheck on fail, then reset
// RL23: timeout_fail_bit high on pulse limit overrun
// RL24: erase_window_bit one when erasure begins
// RL25: suspend takes up to 20us in erase
//
// Implementation choices: the plain strobed port and the address map.
module fcs_host
  import fcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [DATA_W-1:0] flash_dq_in,
  output logic chip_select_n,
  output logic write_strobe_n,
  output logic output_enable_n,
  input wire logic ready_busy_n
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_SETUP = 3'b001, S_PULSE = 3'b010, S_GAP = 3'b011,
    S_POLL = 3'b100, S_RST = 3'b101
  } fcs_state_e;

  fcs_state_e state;
  fcs_state_e next_state;
  logic [3:0] op;
  logic [ADDR_W-1:0] tgt_addr;
  logic [DATA_W-1:0] tgt_data;
  logic [2:0] step;
  logic [3:0] tcnt;
  logic busy;
  logic done;
  logic fail;
  logic ewin;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] dq_s1;
  logic [DATA_W-1:0] dq_s2;
  logic rb_s1;
  logic rb_s2;
  logic have_prev;
  logic prev_tog;
  logic fail_seen;
  fcs_cyc_s cur;

  // command cycle table; reads return we=0
  function automatic fcs_cyc_s seq_cycle(input logic [3:0] o, input logic [2:0] s,
                                         input logic [ADDR_W-1:0] a,
                                         input logic [DATA_W-1:0] d);
    fcs_cyc_s c;
    c = '{we: 1'b1, addr: ADR_U1, data: CMD_UNLK1};
    if (s == 3'd1 || s == 3'd4) c = '{we: 1'b1, addr: ADR_U2, data: CMD_UNLK2};
    if (s == 3'd3) c = '{we: 1'b1, addr: ADR_U1, data: CMD_UNLK1};
    unique case (fcs_op_e'(o))
      OP_READ: c = '{we: 1'b0, addr: a, data: d}; // RL6
      OP_RESET: c = '{we: 1'b1, addr: a, data: CMD_RESET}; // RL7
      OP_SUSP: c = '{we: 1'b1, addr: a, data: CMD_SUSP};
      OP_RESUME: c = '{we: 1'b1, addr: a, data: CMD_RESUME}; // RL11
      OP_BYP_PROG: c = (s == 3'd0) ? '{we: 1'b1, addr: a, data: CMD_PROG}
                                   : '{we: 1'b1, addr: a, data: d}; // RL10
      OP_BYP_EXIT: c = (s == 3'd0) ? '{we: 1'b1, addr: a, data: CMD_ID}
                                   : '{we: 1'b1, addr: a, data: CMD_BYP_EXIT};
      OP_PROG: begin
        if (s == 3'd2) c.data = CMD_PROG;
        if (s == 3'd3) c = '{we: 1'b1, addr: a, data: d}; // RL1 RL2
      end
      OP_ID: begin
        if (s == 3'd2) c.data = CMD_ID;
        if (s == 3'd3) c = '{we: 1'b0, addr: a, data: d}; // RL8 RL9
      end
      OP_BYP_ENTER: if (s == 3'd2) c.data = CMD_BYP;
      OP_CHIP, OP_SECT: begin
        if (s == 3'd2) c.data = CMD_ERASE;
        if (s == 3'd5) c = (fcs_op_e'(o) == OP_CHIP) ? '{we: 1'b1, addr: ADR_U1, data: CMD_CHIP}
          : '{we: 1'b1, addr: {a[17:12], 12'h000}, data: CMD_SECT}; // RL3
      end
      default: c = '{we: 1'b0, addr: a, data: d};
    endcase
    return c;
  endfunction

  function automatic logic [2:0] last_step(input logic [3:0] o);
    unique case (fcs_op_e'(o))
      OP_PROG, OP_ID: return 3'd3;
      OP_BYP_ENTER: return 3'd2;
      OP_CHIP, OP_SECT: return 3'd5;
      OP_BYP_PROG, OP_BYP_EXIT: return 3'd1;
      default: return 3'd0;
    endcase
  endfunction

  assign cur = seq_cycle(op, step, tgt_addr, tgt_data);
  // upper byte zero on command cycles RL5; all writes except reads RL4
  wire is_last = (step == last_step(op));
  wire polls = (fcs_op_e'(op) == OP_PROG) || (fcs_op_e'(op) == OP_BYP_PROG) ||
               (fcs_op_e'(op) == OP_CHIP) || (fcs_op_e'(op) == OP_SECT);
  wire tcnt_end = (state == S_SETUP) ? (tcnt == SETUP_CYC) : (tcnt == PULSE_CYC);
  wire go = reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_GO] && !busy;
  wire tog_now = dq_s2[TOG1_BIT];
  // toggle stops before fail recheck matters RL22 RL19
  wire toggling = have_prev && (tog_now != prev_tog);
  wire poll_ok = (dq_s2[POLL_BIT] == tgt_data[POLL_BIT]); // RL12 RL16
  wire poll_done = have_prev && !toggling && poll_ok;
  wire poll_fail = toggling && fail_seen; // RL23

  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: if (go) next_state = S_SETUP;
      S_SETUP: if (tcnt_end) next_state = S_PULSE;
      S_PULSE: if (tcnt_end) next_state = S_GAP;
      S_GAP: begin
        if (!is_last) next_state = S_SETUP;
        else if (polls) next_state = S_POLL; // RL18
        else next_state = S_IDLE;
      end
      S_POLL: begin
        if (poll_done) next_state = S_IDLE;
        else if (poll_fail) next_state = S_RST; // RL7 RL22
        else next_state = S_SETUP;
      end
      S_RST: next_state = S_SETUP;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= S_IDLE;
      tcnt <= 4'h0;
    end else begin
      state <= next_state;
      tcnt <= (next_state != state) ? 4'h0 : tcnt + 4'h1;
    end
  end

  // poll reads reuse setup/pulse with we cleared
  logic polling;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      op <= 4'h0;
      step <= 3'd0;
      polling <= 1'b0;
      have_prev <= 1'b0;
      prev_tog <= 1'b0;
      fail_seen <= 1'b0;
    end else if (go) begin
      op <= reg_wdata[CTRL_OP_LSB +: 4];
      step <= 3'd0;
      polling <= 1'b0;
      have_prev <= 1'b0;
      fail_seen <= 1'b0;
    end else if (state == S_GAP && !is_last && !polling) begin
      step <= step + 3'd1;
    end else if (state == S_GAP && polls) begin
      polling <= 1'b1;
    end else if (state == S_POLL) begin
      have_prev <= 1'b1;
      prev_tog <= tog_now;
      if (toggling && dq_s2[FAIL_BIT]) fail_seen <= 1'b1; // RL22
    end else if (state == S_RST) begin
      op <= OP_RESET;
      step <= 3'd0;
      polling <= 1'b0;
    end
  end

  wire rd_cycle = polling || !cur.we;
  wire in_pulse = (state == S_PULSE);
  wire active = (state == S_SETUP) || in_pulse;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flash_addr <= '0;
      flash_dq_out <= '0;
      flash_dq_oe <= 1'b0;
      chip_select_n <= 1'b1;
      write_strobe_n <= 1'b1;
      output_enable_n <= 1'b1;
    end else begin
      flash_addr <= polling ? tgt_addr : cur.addr;
      flash_dq_out <= {8'h00, cur.data[7:0]} | (cur.we && is_last && !polling
                      && op != OP_RESET ? cur.data & 16'hFF00 : 16'h0000); // RL5
      flash_dq_oe <= active && !rd_cycle;
      chip_select_n <= !active;
      write_strobe_n <= !(in_pulse && !rd_cycle && next_state == S_PULSE);
      output_enable_n <= !(in_pulse && rd_cycle && next_state == S_PULSE);
    end
  end

  // data sampled through two flops, as it is off the clock
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      rb_s1 <= 1'b1;
      rb_s2 <= 1'b1;
    end else begin
      dq_s1 <= flash_dq_in;
      dq_s2 <= dq_s1;
      rb_s1 <= ready_busy_n;
      rb_s2 <= rb_s1; // RL17
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tgt_addr <= '0;
      tgt_data <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      ewin <= 1'b0;
      rdata <= '0;
    end else begin
      if (reg_wr && reg_addr == REG_ADDR && !busy) tgt_addr <= reg_wdata[ADDR_W-1:0];
      if (reg_wr && reg_addr == REG_DATA && !busy) tgt_data <= reg_wdata[DATA_W-1:0];
      if (go) busy <= 1'b1;
      else if (next_state == S_IDLE && state != S_IDLE) busy <= 1'b0;
      // done is set-wins over software clear
      if (next_state == S_IDLE && state != S_IDLE) done <= 1'b1;
      else if (reg_wr && reg_addr == REG_STAT && reg_wdata[ST_DONE]) done <= 1'b0;
      if (state == S_RST) fail <= 1'b1;
      else if (go) fail <= 1'b0;
      // only sector erase status reads carry the window bit; array data must not
      if (state == S_POLL && fcs_op_e'(op) == OP_SECT && toggling) ewin <= dq_s2[EWIN_BIT]; // RL24
      else if (go) ewin <= 1'b0;
      if (state == S_GAP && rd_cycle && !polling) rdata <= dq_s2;
      else if (poll_done) rdata <= dq_s2;
    end
  end

  wire [31:0] stat_word = {27'h0, rb_s2, ewin, fail, done, busy};
  logic [31:0] next_rdata;
  assign next_rdata = (reg_addr == REG_CTRL) ? {28'h0, op} :
                      (reg_addr == REG_ADDR) ? {14'h0, tgt_addr} :
                      (reg_addr == REG_DATA) ? {16'h0, tgt_data} :
                      (reg_addr == REG_STAT) ? stat_word :
                      (reg_addr == REG_RDATA) ? {16'h0, rdata} : 32'h0;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) reg_rdata <= 32'h0;
    else reg_rdata <= reg_rd ? next_rdata : 32'h0;
  end
endmodule

// ---- fcs_host_chk.sv ----
// pin and register port checks for the flash host sequencer
// assumes bind onto fcs_host, one clock domain
module fcs_host_chk
  import fcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_enable_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  one_strobe_a:
    assert property (write_strobe_n || output_enable_n) else $error("both strobes low");
  we_in_cs_a:
    assert property (!write_strobe_n |-> !chip_select_n) else $error("write unselected");
  read_float_a:
    assert property (!output_enable_n |-> !chip_select_n && !flash_dq_oe)
      else $error("bad read cycle");
  we_drive_a:
    assert property (!write_strobe_n |-> flash_dq_oe) else $error("write not driven");
  we_width_a:
    assert property ($fell(write_strobe_n) |-> !write_strobe_n [*8] ##1 write_strobe_n)
      else $error("write pulse width");
  cs_setup_a:
    assert property ($fell(chip_select_n) |-> (write_strobe_n && output_enable_n) [*5])
      else $error("select setup short");
  held_pins_a:
    assert property (!write_strobe_n && !$fell(write_strobe_n)
      |-> $stable({flash_addr, flash_dq_out})) else $error("pins moved in write");
  rdata_idle_a:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("stray read data");
endmodule
bind fcs_host fcs_host_chk u_chk (.core_clk(core_clk), .rstn(rstn), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
  .flash_dq_oe(flash_dq_oe), .chip_select_n(chip_select_n),
  .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n));

// ---- fcs_flash_model.sv ----
// behavioural nor flash: word program, reset, write status
// assumes dq resolved by the bench; ready pin driven high and low by the model
module fcs_flash_model
  import fcs_pkg::*;
#(
  parameter int BUSY_RD = 4
)
(
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_enable_n,
  input wire logic fail_en,
  output logic [DATA_W-1:0] dq_rd,
  output logic ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] pd = 16'h0;
  logic [DATA_W-1:0] last = 16'h0;
  logic [ADDR_W-1:0] pa = 18'h0;
  logic tog = 1'b0;
  int step = 0;
  int busy = 0;
  int resets = 0;
  wire wstb = chip_select_n | write_strobe_n;
  wire rstb = chip_select_n | output_enable_n;
  // busy counts status reads, not time, to keep runs short
  assign ready_busy_n = (busy == 0);
  always @(negedge wstb) pa = addr;
  always @(posedge wstb) begin
    if (dq[7:0] == 8'hF0) begin
      busy = 0;
      step = 0;
      resets++;
    end else if (busy != 0) step = 0;
    else if (step == 3) begin
      pd = dq;
      busy = fail_en ? -1 : BUSY_RD;
      step = 0;
    end else if (dq[7:0] == 8'hAA && addr[10:0] == 11'h555) step = 1;
    else if (step == 1 && dq[7:0] == 8'h55 && addr[10:0] == 11'h2AA) step = 2;
    else step = (step == 2 && dq[7:0] == 8'hA0) ? 3 : 0;
  end
  always @(posedge rstb) begin
    if (busy != 0) tog = ~tog;
    if (busy > 0) begin
      busy--;
      if (busy == 0) mem[int'(pa)] = pd;
    end
  end
  always @* begin
    if (rstb) dq_rd = ~last; // released bus must not hold stale data
    else begin
      if (busy != 0) dq_rd = {8'h00, ~pd[7], tog, 1'(busy < 0), 5'h00};
      else dq_rd = mem.exists(int'(addr)) ? mem[int'(addr)] : 16'hFFFF;
      last = dq_rd;
    end
  end
endmodule

// ---- tb_fcs_host.sv ----
// self-checking bench for the flash host sequencer
// assumes the flash model on the pins and the bound checker
module tb_fcs_host
  import fcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, fail_en = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, st;
  logic [ADDR_W-1:0] flash_addr;
  logic [DATA_W-1:0] dq_out, dq_rd, dq_in;
  logic dq_oe, cs_n, we_n, oe_n, rb_n;
  int num_errors = 0, checks_done = 0, busy_seen = 0;
  assign dq_in = dq_oe ? dq_out : dq_rd;
  initial forever #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (!rb_n) busy_seen++;
  fcs_host dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr),
    .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in), .chip_select_n(cs_n),
    .write_strobe_n(we_n), .output_enable_n(oe_n), .ready_busy_n(rb_n));
  fcs_flash_model flash (.addr(flash_addr), .dq(dq_in), .chip_select_n(cs_n),
    .write_strobe_n(we_n), .output_enable_n(oe_n), .fail_en(fail_en), .dq_rd(dq_rd),
    .ready_busy_n(rb_n));
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
  // leaves the final status word in st, then clears done
  task automatic run(input fcs_op_e op, input logic [17:0] a, input logic [15:0] d);
    wr(REG_ADDR, 32'(a));
    wr(REG_DATA, 32'(d));
    wr(REG_CTRL, 32'(op) | (32'h1 << CTRL_GO));
    for (int i = 0; i < 2000; i++) begin
      rd(REG_STAT, st);
      if (st[ST_DONE] === 1'b1) break;
      if (i == 1999) begin
        num_errors++;
        print_verdict();
      end
    end
    wr(REG_STAT, 32'h2);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(REG_STAT, st);
    chk("status after reset", st, 32'h10);
    run(OP_READ, 18'h01234, 16'hFFFF);
    rd(REG_RDATA, st);
    chk("blank read", st, 32'hFFFF);
    for (int i = 0; i < 2; i++) begin
      run(OP_PROG, i ? 18'h00AAA : 18'h3F801, i ? 16'h00C3 : 16'h5A3C);
      chk("program status", 32'(st[4:0]), 32'h12);
      run(OP_READ, i ? 18'h00AAA : 18'h3F801, 16'hFFFF);
      rd(REG_RDATA, st);
      chk("programmed word", st, i ? 32'h00C3 : 32'h5A3C);
    end
    chk("busy pin seen", 32'(busy_seen > 0), 32'h1);
    fail_en <= 1'b1;
    run(OP_PROG, 18'h00100, 16'h1234);
    chk("fail flag", 32'(st[ST_FAIL]), 32'h1);
    chk("reset after fail", 32'(flash.resets), 32'h1);
    fail_en <= 1'b0;
    run(OP_READ, 18'h00100, 16'hFFFF);
    rd(REG_RDATA, st);
    chk("failed word", st, 32'hFFFF);
    run(OP_RESET, 18'h0, 16'h0);
    chk("reset command", 32'(flash.resets), 32'h2);
    print_verdict();
  end
endmodule
